/* File: common/ulc_pkg.sv */
// Package for the USB line coding and attach detect block
// Assumes a single 48 MHz clock for the serial path
package ulc_pkg;
  localparam int unsigned CLK_HZ          = 48_000_000;
  localparam int unsigned BIT_HZ          = 12_000_000;
  localparam int unsigned CYC_PER_BIT     = CLK_HZ / BIT_HZ;
  localparam logic [2:0]  STUFF_RUN       = 3'h6;
  localparam logic [4:0]  CRC5_INIT       = 5'h1F;
  localparam logic [4:0]  CRC5_POLY       = 5'h05;
  localparam logic [4:0]  CRC5_RESIDUAL   = 5'h0C;
  localparam logic [15:0] CRC16_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC16_POLY      = 16'h8005;
  localparam logic [15:0] CRC16_RESIDUAL  = 16'h800D;
  localparam logic [1:0]  DIV_RESET       = 2'h0;
  typedef enum logic [1:0] {
    ULC_IDLE = 2'b00,
    ULC_BUSY = 2'b01,
    ULC_DONE = 2'b10
  } ulc_state_t;
endpackage

/* File: common/ulc_crc_if.sv */
// Interface carrying CRC shift requests and state between modules
// Assumes one clock shared by both ends
`timescale 1ns/1ps
interface ulc_crc_if;
  logic        clr;
  logic        shift;
  logic        bit_in;
  logic        sel16;
  logic [4:0]  crc5;
  logic [15:0] crc16;
  modport engine (output clr, output shift, output bit_in, output sel16, input crc5, input crc16);
  modport crc    (input clr, input shift, input bit_in, input sel16, output crc5, output crc16);
endinterface

/* File: logic/ulc_crc.sv */
// Serial CRC5 and CRC16 generator and checker
// Assumes synchronous reset copy from the top module
`timescale 1ns/1ps
module ulc_crc (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Request side
  ulc_crc_if.crc    crc_io
);
  import ulc_pkg::*;

  // --------------------------------------------------------------
  // Shift registers
  // --------------------------------------------------------------
  logic [4:0]  c5_reg;
  logic [15:0] c16_reg;
  logic        fb5;
  logic        fb16;

  assign fb5  = crc_io.bit_in ^ c5_reg[4];
  assign fb16 = crc_io.bit_in ^ c16_reg[15];

  // CRC update per data bit, LSB first stream
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c5_reg  <= CRC5_INIT;
      c16_reg <= CRC16_INIT;
    end else if (crc_io.clr) begin
      c5_reg  <= CRC5_INIT;
      c16_reg <= CRC16_INIT;
    end else if (crc_io.shift) begin
      c5_reg  <= {c5_reg[3:0], 1'b0} ^ (fb5 ? CRC5_POLY : 5'h00);
      c16_reg <= {c16_reg[14:0], 1'b0} ^ (fb16 ? CRC16_POLY : 16'h0000);
    end
  end

  assign crc_io.crc5  = c5_reg;
  assign crc_io.crc16 = c16_reg;
endmodule // ulc_crc

/* File: logic/ulc_line.sv */
// USB line coding: NRZI, bit stuffing, CRC, attach change detect
// Assumes a 48 MHz clock; line pins arrive asynchronously
`timescale 1ns/1ps
module ulc_line (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Control
  input  wire logic i_usb_module_on,
  input  wire logic i_crc16_sel,
  // Transmit bit stream
  input  wire logic i_tx_start,
  input  wire logic i_tx_valid,
  input  wire logic i_tx_bit,
  input  wire logic i_tx_last,
  output logic      o_tx_ready,
  output logic      o_tx_busy,
  // Line pins
  input  wire logic i_dp,
  input  wire logic i_dm,
  output logic      o_dp,
  output logic      o_dm,
  output logic      o_line_oe_n,
  // Receive bit stream
  input  wire logic i_rx_start,
  input  wire logic i_rx_end,
  output logic      o_rx_valid,
  output logic      o_rx_bit,
  output logic      o_rx_stuff_err,
  output logic      o_rx_crc_ok,
  output logic      o_rx_done,
  // Attach detect
  output logic      o_pin_change_interrupt
);
  import ulc_pkg::*;

  // --------------------------------------------------------------
  // Reset release and pin synchronisers
  // --------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic [1:0] dp_sync_reg;
  logic [1:0] dm_sync_reg;
  logic       dp_s;
  logic       dm_s;

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) rst_sync_reg <= 2'h0;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Two-flop pin synchronisers
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_sync_reg <= 2'h3;
      dm_sync_reg <= 2'h0;
    end else begin
      dp_sync_reg <= {dp_sync_reg[0], i_dp};
      dm_sync_reg <= {dm_sync_reg[0], i_dm};
    end
  end
  assign dp_s = dp_sync_reg[1];
  assign dm_s = dm_sync_reg[1];

  // --------------------------------------------------------------
  // Bit-time divider, 48 MHz to 12 Mb/s
  // --------------------------------------------------------------
  logic [1:0] div_reg;
  logic       bit_tick;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) div_reg <= DIV_RESET;
    else div_reg <= div_reg + 2'h1;
  end
  assign bit_tick = (div_reg == 2'(CYC_PER_BIT - 1));

  // --------------------------------------------------------------
  // CRC shared unit
  // --------------------------------------------------------------
  ulc_crc_if crc_bus ();
  ulc_crc u_crc (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .crc_io  (crc_bus.crc)
  );

  // --------------------------------------------------------------
  // Transmit: payload, CRC, stuffing, NRZI
  // --------------------------------------------------------------
  ulc_state_t tx_state_reg;
  logic       tx_in_crc_reg;
  logic [3:0] tx_crc_cnt_reg;
  logic [15:0] tx_crc_reg;
  logic       tx_load_reg;
  logic [2:0] tx_ones_reg;
  logic       tx_line_reg;
  logic       tx_stuff;
  logic       tx_data_bit;
  logic       tx_take;
  logic       tx_crc_bit;

  assign tx_stuff    = (tx_ones_reg == STUFF_RUN);
  assign tx_crc_bit  = ~tx_crc_reg[15];
  assign tx_take     = bit_tick && (tx_state_reg == ULC_BUSY) && !tx_stuff && !tx_in_crc_reg && i_tx_valid;
  assign o_tx_ready  = bit_tick && (tx_state_reg == ULC_BUSY) && !tx_stuff && !tx_in_crc_reg;
  assign tx_data_bit = tx_in_crc_reg ? tx_crc_bit : i_tx_bit;
  assign o_tx_busy   = (tx_state_reg == ULC_BUSY);

  // Packet sequencing
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg   <= ULC_IDLE;
      tx_in_crc_reg  <= 1'b0;
      tx_crc_cnt_reg <= 4'h0;
      tx_crc_reg     <= 16'h0000;
      tx_load_reg    <= 1'b0;
    end else begin
      // Load one cycle late, so the last payload bit is in the CRC
      tx_load_reg <= 1'b0;
      unique case (tx_state_reg)
        ULC_IDLE: begin
          if (i_tx_start && i_usb_module_on) tx_state_reg <= ULC_BUSY;
          tx_in_crc_reg <= 1'b0;
        end
        ULC_BUSY: begin
          if (tx_take && i_tx_last) begin
            tx_in_crc_reg  <= 1'b1;
            tx_crc_cnt_reg <= i_crc16_sel ? 4'hF : 4'h4;
            tx_load_reg    <= 1'b1;
          end else if (tx_load_reg) begin
            tx_crc_reg <= i_crc16_sel ? crc_bus.crc16 : {crc_bus.crc5, 11'h000};
          end else if (bit_tick && tx_in_crc_reg && !tx_stuff) begin
            tx_crc_reg <= {tx_crc_reg[14:0], 1'b0};
            if (tx_crc_cnt_reg == 4'h0) tx_state_reg <= ULC_DONE;
            else tx_crc_cnt_reg <= tx_crc_cnt_reg - 4'h1;
          end
        end
        ULC_DONE: tx_state_reg <= ULC_IDLE;
        default:  tx_state_reg <= ULC_IDLE;
      endcase
    end
  end

  // Ones run and NRZI line state
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ones_reg <= 3'h0;
      tx_line_reg <= 1'b1;
    end else if (tx_state_reg != ULC_BUSY) begin
      tx_ones_reg <= 3'h0;
      tx_line_reg <= 1'b1;
    end else if (bit_tick) begin
      if (tx_stuff) begin
        tx_ones_reg <= 3'h0;
        tx_line_reg <= ~tx_line_reg;
      end else if (tx_in_crc_reg || i_tx_valid) begin
        if (tx_data_bit) begin
          tx_ones_reg <= tx_ones_reg + 3'h1;
        end else begin
          tx_ones_reg <= 3'h0;
          tx_line_reg <= ~tx_line_reg;
        end
      end
    end
  end

  // Differential drive, J is D+ high
  assign o_dp        = tx_line_reg;
  assign o_dm        = ~tx_line_reg;
  assign o_line_oe_n = ~(tx_state_reg == ULC_BUSY);

  // --------------------------------------------------------------
  // Receive: NRZI decode, unstuff, CRC check
  // --------------------------------------------------------------
  logic       rx_act_reg;
  logic       rx_prev_reg;
  logic [2:0] rx_ones_reg;
  logic       rx_dec;
  logic       rx_stuffed;
  logic       rx_valid_reg;
  logic       rx_bit_reg;
  logic       rx_err_reg;
  logic       rx_ok_reg;
  logic       rx_done_reg;

  assign rx_dec     = (dp_s == rx_prev_reg);
  assign rx_stuffed = (rx_ones_reg == STUFF_RUN);

  // Decoder and unstuffer state
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_act_reg   <= 1'b0;
      rx_prev_reg  <= 1'b1;
      rx_ones_reg  <= 3'h0;
      rx_valid_reg <= 1'b0;
      rx_bit_reg   <= 1'b0;
      rx_err_reg   <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      if (i_rx_start && i_usb_module_on) begin
        rx_act_reg  <= 1'b1;
        rx_prev_reg <= dp_s;
        rx_ones_reg <= 3'h0;
        rx_err_reg  <= 1'b0;
      end else if (i_rx_end) begin
        rx_act_reg <= 1'b0;
      end else if (rx_act_reg && bit_tick) begin
        rx_prev_reg <= dp_s;
        if (rx_stuffed) begin
          rx_ones_reg <= 3'h0;
          if (rx_dec) rx_err_reg <= 1'b1;
        end else begin
          rx_ones_reg  <= rx_dec ? rx_ones_reg + 3'h1 : 3'h0;
          rx_valid_reg <= 1'b1;
          rx_bit_reg   <= rx_dec;
        end
      end
    end
  end

  // CRC request routing, transmit has priority while busy, receive otherwise
  assign crc_bus.sel16  = i_crc16_sel;
  assign crc_bus.clr    = (i_tx_start && tx_state_reg == ULC_IDLE) || (i_rx_start && i_usb_module_on);
  assign crc_bus.shift  = (tx_state_reg == ULC_BUSY) ? tx_take
                          : (rx_act_reg && bit_tick && !rx_stuffed && !i_rx_end);
  assign crc_bus.bit_in = (tx_state_reg == ULC_BUSY) ? i_tx_bit : rx_dec;

  // Residual check at packet end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ok_reg   <= 1'b0;
      rx_done_reg <= 1'b0;
    end else begin
      rx_done_reg <= rx_act_reg && i_rx_end;
      if (rx_act_reg && i_rx_end)
        rx_ok_reg <= i_crc16_sel ? (crc_bus.crc16 == CRC16_RESIDUAL)
                                 : (crc_bus.crc5 == CRC5_RESIDUAL);
    end
  end

  assign o_rx_valid     = rx_valid_reg;
  assign o_rx_bit       = rx_bit_reg;
  assign o_rx_stuff_err = rx_err_reg;
  assign o_rx_crc_ok    = rx_ok_reg;
  assign o_rx_done      = rx_done_reg;

  // --------------------------------------------------------------
  // Attach change detect on D+ and D-
  // --------------------------------------------------------------
  logic dp_last_reg;
  logic dm_last_reg;
  logic chg_reg;

  // Edge compare on synchronised levels, gated by module off
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_last_reg <= 1'b1;
      dm_last_reg <= 1'b0;
      chg_reg     <= 1'b0;
    end else begin
      dp_last_reg <= dp_s;
      dm_last_reg <= dm_s;
      chg_reg     <= !i_usb_module_on &&
                     ((dp_s != dp_last_reg) || (dm_s != dm_last_reg));
    end
  end
  assign o_pin_change_interrupt = chg_reg;
endmodule // ulc_line

/* File: bench/ulc_line_chk.sv */
// Assertions on the line coding top module ports
// Assumes one clock and the raw active-low reset
`timescale 1ns/1ps
module ulc_line_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_usb_module_on,
  input wire logic i_tx_start,
  input wire logic i_tx_valid,
  input wire logic i_tx_bit,
  input wire logic o_tx_ready,
  input wire logic o_line_oe_n,
  input wire logic o_dp,
  input wire logic o_dm,
  input wire logic i_dp,
  input wire logic i_rx_end,
  input wire logic o_rx_valid,
  input wire logic o_rx_done,
  input wire logic o_pin_change_interrupt
);
  logic [2:0] ones_cnt_reg;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Run of taken one bits, cleared by a zero or the stuffed flip
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) ones_cnt_reg <= 3'h0;
    else if (i_tx_start || (o_tx_ready && i_tx_valid && !i_tx_bit)) ones_cnt_reg <= 3'h0;
    else if (ones_cnt_reg == 3'h6 && $changed(o_dp)) ones_cnt_reg <= 3'h0;
    else if (o_tx_ready && i_tx_valid) ones_cnt_reg <= ones_cnt_reg + 3'h1;
  end
  property p_zero_flip; o_tx_ready && i_tx_valid && !i_tx_bit |=> o_dp != $past(o_dp); endproperty
  a_zero_flip: assert property (p_zero_flip) else $error("zero bit did not flip line");
  property p_one_hold; o_tx_ready && i_tx_valid && i_tx_bit |=> $stable(o_dp); endproperty
  a_one_hold: assert property (p_one_hold) else $error("one bit moved line");
  property p_jk; !o_line_oe_n |-> o_dm == !o_dp; endproperty
  a_jk: assert property (p_jk) else $error("line not J or K");
  property p_stuff_gap; ones_cnt_reg == 3'h6 |-> !o_tx_ready; endproperty
  a_stuff_gap: assert property (p_stuff_gap) else $error("slot open where stuff due");
  property p_stuff_flip; o_tx_ready && i_tx_valid && i_tx_bit && ones_cnt_reg == 3'h5 |=> ##[1:5] $changed(o_dp);
  endproperty
  a_stuff_flip: assert property (p_stuff_flip) else $error("no stuffed flip");
  property p_tick; o_tx_ready |=> !o_tx_ready [*3]; endproperty
  a_tick: assert property (p_tick) else $error("bit slots too close");
  property p_on_quiet; i_usb_module_on |-> !o_pin_change_interrupt; endproperty
  a_on_quiet: assert property (p_on_quiet) else $error("change event while on");
  property p_change; !i_usb_module_on && $changed(i_dp) |-> ##[1:4] (o_pin_change_interrupt || i_usb_module_on);
  endproperty
  a_change: assert property (p_change) else $error("missed change event");
  property p_rx_done; o_rx_done |-> $past(i_rx_end); endproperty
  a_rx_done: assert property (p_rx_done) else $error("done without end");
  property p_rx_pulse; o_rx_valid |=> !o_rx_valid; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx valid too long");
endmodule // ulc_line_chk
bind ulc_line ulc_line_chk ulc_line_chk_inst (.*);

/* File: bench/ulc_host_model.sv */
// Host side of the cable: NRZI drive of D+ and D-
// Assumes the bench steps one bit per call
`timescale 1ns/1ps
module ulc_host_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_step,
  input  wire logic i_bit,
  output logic      o_dp,
  output logic      o_dm
);
  logic line_reg;
  // Zero flips the line, one holds it; idle is J
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) line_reg <= 1'b1;
    else if (i_step && !i_bit) line_reg <= !line_reg;
  end
  assign o_dp = line_reg;
  assign o_dm = !line_reg;
endmodule // ulc_host_model

/* File: bench/tb_top.sv */
// Testbench for the line coding and attach detect block
// Assumes host model on the line, device drive wins when enabled
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_n = 0, on = 0, tx_start = 0, tx_valid = 0, tx_bit = 0, tx_last = 0;
  logic rx_start = 0, rx_end = 0, h_step = 0, h_bit = 1;
  logic tx_ready, tx_busy, d_dp, d_dm, oe_n, h_dp, h_dm, rx_valid, rx_bit, s_err, chg, done, rx_crc_ok;
  int num_errors = 0, compares = 0, chg_cnt = 0, done_cnt = 0;
  logic q[$];
  always #5 clk = ~clk;
  ulc_line ulc_line_inst (.i_clk(clk), .i_rst_n(rst_n), .i_usb_module_on(on), .i_crc16_sel(1'b0),
    .i_tx_start(tx_start), .i_tx_valid(tx_valid), .i_tx_bit(tx_bit), .i_tx_last(tx_last), .o_tx_ready(tx_ready),
    .o_tx_busy(tx_busy), .i_dp(oe_n === 1'b0 ? d_dp : h_dp), .i_dm(oe_n === 1'b0 ? d_dm : h_dm), .o_dp(d_dp),
    .o_dm(d_dm), .o_line_oe_n(oe_n), .i_rx_start(rx_start), .i_rx_end(rx_end), .o_rx_valid(rx_valid),
    .o_rx_bit(rx_bit), .o_rx_stuff_err(s_err), .o_rx_crc_ok(rx_crc_ok), .o_rx_done(done),
    .o_pin_change_interrupt(chg));
  ulc_host_model ulc_host_model_inst (.i_clk(clk), .i_rst_n(rst_n), .i_step(h_step), .i_bit(h_bit),
    .o_dp(h_dp), .o_dm(h_dm));
  // Event counters and decoded bit log, sampled where settled
  always @(negedge clk) begin
    chg_cnt += (chg === 1'b1);
    done_cnt += (done === 1'b1);
    if (rx_valid === 1'b1) q.push_back(rx_bit);
  end
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1;
    @(negedge clk) s = 0;
  endtask
  // One host bit, held four cycles
  task automatic host_bit(input logic b);
    h_bit = b;
    pulse(h_step);
    repeat (2) @(negedge clk);
  endtask
  task automatic t_change;
    chg_cnt = 0;
    host_bit(1'b0);
    repeat (3) @(negedge clk);
    check(chg_cnt != 0, "no change event");
    pulse(tx_start);
    check(tx_busy === 1'b0, "start taken while off");
    @(negedge clk) on = 1;
    chg_cnt = 0;
    host_bit(1'b0);
    repeat (3) @(negedge clk);
    check(chg_cnt == 0, "change event while on");
  endtask
  // Token-sized frame with a good CRC5, aligned to the bit tick
  task automatic t_crc;
    logic [15:0] frame;
    logic [4:0] c;
    int n;
    frame = 16'h00A5;
    c = ulc_pkg::CRC5_INIT;
    for (int i = 0; i < 11; i++) c = {c[3:0], 1'b0} ^ ((frame[i] ^ c[4]) ? ulc_pkg::CRC5_POLY : 5'h00);
    for (int j = 0; j < 5; j++) frame[11+j] = ~c[4-j];
    pulse(rx_start);
    n = 0;
    while (rx_valid !== 1'b1 && n < 20) begin @(negedge clk); n++; end
    check(n < 20, "no rx bit slot");
    done_cnt = 0;
    rx_start = 1;
    h_bit = frame[0];
    h_step = 1;
    @(negedge clk);
    rx_start = 0;
    h_step = 0;
    repeat (2) @(negedge clk);
    for (int i = 1; i < 16; i++) host_bit(frame[i]);
    repeat (2) @(negedge clk);
    pulse(rx_end);
    repeat (2) @(negedge clk);
    check(done_cnt == 1 && rx_crc_ok === 1'b1, "good crc5 rejected");
  endtask
  task automatic t_tx;
    logic [7:0] pat;
    logic pre;
    int n;
    pat = 8'hFE;
    pulse(tx_start);
    @(negedge clk);
    check(tx_busy === 1'b1 && oe_n === 1'b0, "not driving");
    for (int i = 0; i < 8; i++) begin
      tx_valid = 1;
      tx_bit = pat[i];
      tx_last = (i == 7);
      n = 0;
      while (tx_ready !== 1'b1 && n < 20) begin @(negedge clk); n++; end
      pre = d_dp;
      @(negedge clk);
      check(n < 20 && d_dp === (pat[i] ? pre : !pre), "line coding");
    end
    tx_valid = 0;
    tx_last = 0;
    n = 0;
    while (tx_busy === 1'b1 && n < 300) begin @(negedge clk); n++; end
    check(n < 300 && oe_n === 1'b1, "packet never ended");
  endtask
  task automatic t_rx;
    logic [9:0] sent;
    logic [8:0] want;
    logic hit, ok;
    sent = 10'h27E; // Six ones, then the stuffed zero
    want = 9'h17E;
    hit = 0;
    q.delete();
    done_cnt = 0;
    pulse(rx_start);
    for (int i = 0; i < 10; i++) host_bit(sent[i]);
    repeat (8) host_bit(1'b1);
    pulse(rx_end);
    repeat (3) @(negedge clk);
    check(done_cnt == 1, "no rx done");
    check(s_err === 1'b1, "long run of ones not flagged");
    for (int k = 0; k + 9 <= q.size(); k++) begin
      ok = 1;
      for (int j = 0; j < 9; j++) if (q[k+j] !== want[j]) ok = 0;
      if (ok) hit = 1;
    end
    check(hit, "decoded stream wrong");
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    t_change();
    t_tx();
    t_rx();
    t_crc();
    finish_test();
  end
endmodule // tb_top
